// File: hw/p2g_port.sv
// Eight-pin general-purpose port with timer pin sharing, APB register slave.
// Assumes pins arrive asynchronously; timer compare outputs share clk.
//
// Operation
// RULE1: Eight bidirectional pins, same function selection in every chip mode.
// RULE2: Direction bit 1 makes the pin output, 0 makes it input.
// RULE3: Direction register is write-only; reads return a fixed meaningless value.
// RULE4: Software writes the direction register as whole bytes only.
// RULE5: Direction clears on power-on reset and hardware standby, kept otherwise.
// RULE6: After manual reset pins follow only retained direction and output data.
// RULE7: Readable and writable output latch, one bit per pin.
// RULE8: Output latch clears on power-on reset and hardware standby, kept otherwise.
// RULE9: Pin readback register is read-only; writes are ignored.
// RULE10: Readback gives latch bit for outputs and live pin for inputs.
// RULE11: Readback shows pin levels after clear, retained over manual reset.
// RULE12: Pins 7 and 6 carry timer compare output when output-select is nonzero.
// RULE13: Pin 5 feeds timer 1 external clock when external clock selected.
// RULE14: Pin 4 feeds timer 1 clear when both clear-select bits are set.
// RULE15: Pin 3 feeds timer 0 external clock when external clock selected.
// RULE16: Pin 2 feeds timer 0 clear when both clear-select bits are set.
// RULE17: Pins 1 and 0 are plain pins steered by direction bits.
// RULE18: General outputs drive the latch bit; inputs release the driver.
`timescale 1ns/1ps
module p2g_port (
  input wire logic clk,
  input wire logic rst_n,
  input wire logic manRst_n,
  input wire logic hwStandby,
  input wire logic [7:0] pinIn,
  output logic [7:0] pinOut,
  output logic [7:0] pinOe,
  input wire logic timer0CompareOut,
  input wire logic timer1CompareOut,
  output logic timer0ExtClockIn,
  output logic timer1ExtClockIn,
  output logic timer0ClearIn,
  output logic timer1ClearIn,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [p2g_pkg::PADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr
);
  import p2g_pkg::*;

  logic rstMeta;
  logic rstSync;
  logic [7:0] dirReg;
  logic [7:0] latchReg;
  logic [17:0] tselReg;
  logic [7:0] pinSync;
  logic hwStby;
  logic manRst;
  logic [7:0] readback;
  logic [31:0] readVal;
  logic accStart;
  logic wrEn;
  p2g_reg_t accSel;
  logic [3:0] outSel0;
  logic [3:0] outSel1;
  logic [2:0] clkSel0;
  logic [2:0] clkSel1;
  logic [1:0] clrSel0;
  logic [1:0] clrSel1;

  p2g_sync_if sIf ();

  function automatic p2g_reg_t regSel(input logic [PADDR_W-1:0] addr);
    unique case (addr)
      ADDR_DIR: regSel = REG_DIR;
      ADDR_LATCH: regSel = REG_LATCH;
      ADDR_READBACK: regSel = REG_READBACK;
      ADDR_TSEL: regSel = REG_TSEL;
      default: regSel = REG_NONE;
    endcase
  endfunction

  function automatic logic extClk(input logic [2:0] cks);
    extClk = (cks >= CKS_EXT_MIN);
  endfunction

  // Reset release
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  assign sIf.raw = {~manRst_n, hwStandby, pinIn};

  p2g_sync u_sync (
    .clk(clk),
    .rstN(rstSync),
    .sIf(sIf.syncer)
  );

  assign pinSync = sIf.synced[7:0];
  assign hwStby = sIf.synced[SY_HWSTBY];
  assign manRst = sIf.synced[SY_MANRST];

  assign outSel0 = tselReg[TS_OUTSEL0_LSB +: 4];
  assign outSel1 = tselReg[TS_OUTSEL1_LSB +: 4];
  assign clkSel0 = tselReg[TS_CLKSEL0_LSB +: 3];
  assign clkSel1 = tselReg[TS_CLKSEL1_LSB +: 3];
  assign clrSel0 = tselReg[TS_CLRSEL0_LSB +: 2];
  assign clrSel1 = tselReg[TS_CLRSEL1_LSB +: 2];

  // Bus decode
  assign accSel = regSel(paddr);
  assign accStart = psel & penable & ~pready;
  assign wrEn = psel & penable & pready & pwrite;

  // Output bits take the latch, input bits the live pin
  assign readback = (dirReg & latchReg) | (~dirReg & pinSync); // see RULE10 see RULE11

  chk_readback_mux: assert property ( // see RULE10
    @(posedge clk) disable iff (!rstSync)
    (accStart && !pwrite && accSel == REG_READBACK) |=>
      pready && (prdata[7:0] == (($past(dirReg) & $past(latchReg)) |
      (~$past(dirReg) & $past(pinSync)))) && (prdata[31:8] == 24'h000000))
    else $error("readback value wrong");

  always_comb begin
    readVal = 32'h00000000;
    unique case (accSel)
      REG_DIR: readVal = {24'h000000, DIR_READ_VAL}; // see RULE3
      REG_LATCH: readVal = {24'h000000, latchReg};
      REG_READBACK: readVal = {24'h000000, readback};
      REG_TSEL: readVal = {14'h0000, tselReg};
      REG_NONE: readVal = 32'h00000000;
    endcase
  end

  // One wait state, then the answer
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pready <= 1'b0;
    end else begin
      pready <= accStart;
    end
  end

  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      prdata <= 32'h00000000;
      pslverr <= 1'b0;
    end else if (accStart) begin
      prdata <= pwrite ? 32'h00000000 : readVal;
      pslverr <= (accSel == REG_NONE);
    end else begin
      pslverr <= 1'b0;
    end
  end

  chk_dir_unread: assert property ( // see RULE3
    @(posedge clk) disable iff (!rstSync)
    (accStart && !pwrite && accSel == REG_DIR) |=> (prdata == 32'h00000000) && pready)
    else $error("direction register leaked on read");

  chk_ready_wait: assert property (
    @(posedge clk) disable iff (!rstSync)
    accStart |=> pready)
    else $error("no answer after one wait state");

  chk_ready_pulse: assert property (
    @(posedge clk) disable iff (!rstSync)
    pready |=> !pready)
    else $error("ready held longer than one cycle");

  chk_bad_addr: assert property (
    @(posedge clk) disable iff (!rstSync)
    (accStart && accSel == REG_NONE) |=> pslverr && pready)
    else $error("unmapped access not flagged");

  // Direction register, byte-wide writes only
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      dirReg <= DIR_RST;
    end else if (hwStby) begin
      dirReg <= DIR_RST; // see RULE5
    end else if (wrEn && accSel == REG_DIR) begin
      dirReg <= pwdata[7:0]; // see RULE4
    end
  end

  chk_dir_write: assert property ( // see RULE2
    @(posedge clk) disable iff (!rstSync)
    (wrEn && accSel == REG_DIR && !hwStby) |=> (dirReg == $past(pwdata[7:0])))
    else $error("direction write lost");

  chk_hwstby_clear: assert property ( // see RULE5
    @(posedge clk) disable iff (!rstSync)
    hwStby |=> (dirReg == DIR_RST) && (latchReg == LATCH_RST) ##1 (pinOe == 8'h00))
    else $error("hardware standby did not clear port");

  // Output latch; readback writes never reach it
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      latchReg <= LATCH_RST;
    end else if (hwStby) begin
      latchReg <= LATCH_RST; // see RULE8
    end else if (wrEn && accSel == REG_LATCH) begin
      latchReg <= pwdata[7:0]; // see RULE7 see RULE9
    end
  end

  chk_write_latch: assert property ( // see RULE7
    @(posedge clk) disable iff (!rstSync)
    (wrEn && accSel == REG_LATCH && !hwStby) |=> (latchReg == $past(pwdata[7:0])))
    else $error("latch write lost");

  chk_ro_ignore: assert property ( // see RULE9
    @(posedge clk) disable iff (!rstSync)
    (wrEn && accSel == REG_READBACK && !hwStby) |=> $stable(latchReg) && $stable(dirReg))
    else $error("readback write changed state");

  // Timer selection, cleared with the timers on manual reset
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      tselReg <= TSEL_RST;
    end else if (hwStby || manRst) begin
      tselReg <= TSEL_RST; // see RULE6
    end else if (wrEn && accSel == REG_TSEL) begin
      tselReg <= pwdata[17:0];
    end
  end

  chk_manrst_keep: assert property ( // see RULE6
    @(posedge clk) disable iff (!rstSync)
    (manRst && !hwStby && !wrEn) |=> $stable(dirReg) && $stable(latchReg) &&
      (tselReg == TSEL_RST))
    else $error("manual reset handled wrongly");

  chk_tsel_stby: assert property ( // see RULE6
    @(posedge clk) disable iff (!rstSync)
    (hwStby || manRst) |=> (tselReg == TSEL_RST))
    else $error("timer selection not cleared");

  // Pin drivers, identical in every chip mode
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      pinOe <= 8'h00;
      pinOut <= 8'h00;
    end else begin
      pinOe <= dirReg; // see RULE1 see RULE2 see RULE17 see RULE18
      pinOut <= latchReg; // see RULE18
      if (|outSel1) begin
        pinOe[PIN_CMP1] <= 1'b1; // see RULE12
        pinOut[PIN_CMP1] <= timer1CompareOut;
      end
      if (|outSel0) begin
        pinOe[PIN_CMP0] <= 1'b1; // see RULE12
        pinOut[PIN_CMP0] <= timer0CompareOut;
      end
    end
  end

  chk_plain_pins: assert property ( // see RULE17
    @(posedge clk) disable iff (!rstSync)
    ##1 (pinOe[1:0] == $past(dirReg[1:0])) && (pinOut[1:0] == $past(latchReg[1:0])))
    else $error("plain pins do not follow direction and latch");

  chk_mid_pins: assert property ( // see RULE18
    @(posedge clk) disable iff (!rstSync)
    ##1 (pinOe[5:2] == $past(dirReg[5:2])) && (pinOut[5:2] == $past(latchReg[5:2])))
    else $error("timer input pins do not follow direction and latch");

  chk_tmo_pin: assert property ( // see RULE12
    @(posedge clk) disable iff (!rstSync)
    (|outSel1) |=> pinOe[PIN_CMP1] && (pinOut[PIN_CMP1] == $past(timer1CompareOut)))
    else $error("pin 7 does not carry timer 1 compare output");

  chk_cmp0_pin: assert property ( // see RULE12
    @(posedge clk) disable iff (!rstSync)
    (|outSel0) |=> pinOe[PIN_CMP0] && (pinOut[PIN_CMP0] == $past(timer0CompareOut)))
    else $error("pin 6 does not carry timer 0 compare output");

  chk_tmo_off: assert property ( // see RULE18
    @(posedge clk) disable iff (!rstSync)
    (outSel0 == 4'h0) |=> (pinOe[PIN_CMP0] == $past(dirReg[PIN_CMP0])))
    else $error("pin 6 direction ignored with timer output off");

  chk_cmp1_off: assert property ( // see RULE18
    @(posedge clk) disable iff (!rstSync)
    (outSel1 == 4'h0) |=> (pinOe[PIN_CMP1] == $past(dirReg[PIN_CMP1])) &&
      (pinOut[PIN_CMP1] == $past(latchReg[PIN_CMP1])))
    else $error("pin 7 ignores direction and latch with timer output off");

  // Timer inputs taken from pins
  always_ff @(posedge clk or negedge rstSync) begin
    if (!rstSync) begin
      timer1ExtClockIn <= 1'b0;
      timer1ClearIn <= 1'b0;
      timer0ExtClockIn <= 1'b0;
      timer0ClearIn <= 1'b0;
    end else begin
      timer1ExtClockIn <= extClk(clkSel1) & pinSync[PIN_ECLK1]; // see RULE13
      timer1ClearIn <= (&clrSel1) & pinSync[PIN_CLR1]; // see RULE14
      timer0ExtClockIn <= extClk(clkSel0) & pinSync[PIN_ECLK0]; // see RULE15
      timer0ClearIn <= (&clrSel0) & pinSync[PIN_CLR0]; // see RULE16
    end
  end

  chk_ext_clock: assert property ( // see RULE13
    @(posedge clk) disable iff (!rstSync)
    extClk(clkSel1) |=> (timer1ExtClockIn == $past(pinSync[PIN_ECLK1])))
    else $error("pin 5 not routed to timer 1 clock");

  chk_clk1_off: assert property ( // see RULE13
    @(posedge clk) disable iff (!rstSync)
    !extClk(clkSel1) |=> !timer1ExtClockIn)
    else $error("timer 1 clock fed without selection");

  chk_clk0_route: assert property ( // see RULE15
    @(posedge clk) disable iff (!rstSync)
    extClk(clkSel0) |=> (timer0ExtClockIn == $past(pinSync[PIN_ECLK0])))
    else $error("pin 3 not routed to timer 0 clock");

  chk_clear_in: assert property ( // see RULE16
    @(posedge clk) disable iff (!rstSync)
    (clrSel0 != 2'b11) |=> !timer0ClearIn)
    else $error("timer 0 clear asserted without selection");

  chk_clear0_route: assert property ( // see RULE16
    @(posedge clk) disable iff (!rstSync)
    (&clrSel0) |=> (timer0ClearIn == $past(pinSync[PIN_CLR0])))
    else $error("pin 2 not routed to timer 0 clear");

  chk_clear1_route: assert property ( // see RULE14
    @(posedge clk) disable iff (!rstSync)
    (&clrSel1) |=> (timer1ClearIn == $past(pinSync[PIN_CLR1])))
    else $error("pin 4 not routed to timer 1 clear");

  chk_clear1_off: assert property ( // see RULE14
    @(posedge clk) disable iff (!rstSync)
    (clrSel1 != 2'b11) |=> !timer1ClearIn)
    else $error("timer 1 clear asserted without selection");
endmodule

// File: hw/p2g_pkg.sv
// Constants, register map and types for the eight-pin port block.
// Assumes an APB master with 32-bit data and 18-bit byte addresses.
package p2g_pkg;
  localparam int PADDR_W = 18;
  localparam int SYNC_W = 10;
  // Register indices; byte address is four times the index
  localparam logic [15:0] IDX_DIR = 16'hFEB1;
  localparam logic [15:0] IDX_READBACK = 16'hFF51;
  localparam logic [15:0] IDX_LATCH = 16'hFF61;
  localparam logic [15:0] IDX_TSEL = 16'hFF70;
  localparam logic [PADDR_W-1:0] ADDR_DIR = {IDX_DIR, 2'b00};
  localparam logic [PADDR_W-1:0] ADDR_READBACK = {IDX_READBACK, 2'b00};
  localparam logic [PADDR_W-1:0] ADDR_LATCH = {IDX_LATCH, 2'b00};
  localparam logic [PADDR_W-1:0] ADDR_TSEL = {IDX_TSEL, 2'b00};
  // Reset values
  localparam logic [7:0] DIR_RST = 8'h00;
  localparam logic [7:0] LATCH_RST = 8'h00;
  localparam logic [17:0] TSEL_RST = 18'h00000;
  // Value returned on a read of the write-only direction register
  localparam logic [7:0] DIR_READ_VAL = 8'h00;
  // Timer selection register fields
  localparam int TS_OUTSEL0_LSB = 0;
  localparam int TS_OUTSEL1_LSB = 4;
  localparam int TS_CLKSEL0_LSB = 8;
  localparam int TS_CLKSEL1_LSB = 11;
  localparam int TS_CLRSEL0_LSB = 14;
  localparam int TS_CLRSEL1_LSB = 16;
  // Clock-select codes at or above this value pick the external clock
  localparam logic [2:0] CKS_EXT_MIN = 3'h5;
  // Pin positions
  localparam int PIN_CLR0 = 2;
  localparam int PIN_ECLK0 = 3;
  localparam int PIN_CLR1 = 4;
  localparam int PIN_ECLK1 = 5;
  localparam int PIN_CMP0 = 6;
  localparam int PIN_CMP1 = 7;
  // Positions inside the synchronised vector
  localparam int SY_HWSTBY = 8;
  localparam int SY_MANRST = 9;
  typedef enum {REG_NONE, REG_DIR, REG_LATCH, REG_READBACK, REG_TSEL} p2g_reg_t;
endpackage

// File: hw/p2g_sync_if.sv
// Carries raw outside levels to the synchroniser and the clean copies back.
// Assumes one clock domain on the user side.
`timescale 1ns/1ps
interface p2g_sync_if;
  logic [p2g_pkg::SYNC_W-1:0] raw;
  logic [p2g_pkg::SYNC_W-1:0] synced;
  modport syncer (input raw, output synced);
  modport user (output raw, input synced);
endinterface

// File: hw/p2g_sync.sv
// Two-flop synchroniser for pin levels, standby and manual reset inputs.
// Assumes rstN is already synchronous to clk.
`timescale 1ns/1ps
module p2g_sync (
  input wire logic clk,
  input wire logic rstN,
  p2g_sync_if.syncer sIf
);
  import p2g_pkg::*;

  logic [SYNC_W-1:0] meta;

  always_ff @(posedge clk or negedge rstN) begin
    if (!rstN) begin
      meta <= '0;
      sIf.synced <= '0;
    end else begin
      meta <= sIf.raw;
      sIf.synced <= meta;
    end
  end
endmodule

// File: tb/p2g_pins.sv
// Outside world of the port: pin wires and the two timer compare outputs.
// Assumes registered pinOut and pinOe from the port.
`timescale 1ns/1ps
module p2g_pins (
  input wire logic [7:0] pinOut,
  input wire logic [7:0] pinOe,
  input wire logic [7:0] extLevel,
  input wire logic [1:0] cmpLevel,
  output logic [7:0] pinIn,
  output logic timer0CompareOut,
  output logic timer1CompareOut
);
  // Driven pins show the port value, released pins the outside level
  assign pinIn = (pinOe & pinOut) | (~pinOe & extLevel);
  assign timer0CompareOut = cmpLevel[0];
  assign timer1CompareOut = cmpLevel[1];
endmodule

// File: tb/pin_level_readback_gpio_with_timer_pins_test.sv
// Self-checking bench for the port block.
// Assumes the port answers APB with a wait state and syncs pins in 2 edges.
`timescale 1ns/1ps
module pin_level_readback_gpio_with_timer_pins_test;
  import p2g_pkg::*;
  logic clk, rst_n, manRst_n, hwStandby, psel, penable, pwrite, pready, pslverr, err;
  logic t0Clk, t1Clk, t0Clr, t1Clr, t0Cmp, t1Cmp;
  logic [PADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic [7:0] pinIn, pinOut, pinOe, extLevel;
  logic [1:0] cmpLevel;
  int n_fail, checked;
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end
  p2g_port i_p2g_port (.clk(clk), .rst_n(rst_n), .manRst_n(manRst_n),
    .hwStandby(hwStandby), .pinIn(pinIn), .pinOut(pinOut), .pinOe(pinOe),
    .timer0CompareOut(t0Cmp), .timer1CompareOut(t1Cmp), .timer0ExtClockIn(t0Clk),
    .timer1ExtClockIn(t1Clk), .timer0ClearIn(t0Clr), .timer1ClearIn(t1Clr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
    .prdata(prdata), .pready(pready), .pslverr(pslverr));
  p2g_pins i_p2g_pins (.pinOut(pinOut), .pinOe(pinOe), .extLevel(extLevel),
    .cmpLevel(cmpLevel), .pinIn(pinIn), .timer0CompareOut(t0Cmp),
    .timer1CompareOut(t1Cmp));
  task automatic test_done();
    $display("checked %0d n_fail %0d", checked, n_fail);
    if (n_fail == 0 && checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  task automatic checkWord(string name, logic [31:0] e, logic [31:0] g);
    checked++;
    if (g !== e) begin
      n_fail++;
      $display("[ERR] %s expected %h seen %h", name, e, g);
    end
  endtask
  task automatic checkPin(string name, logic [7:0] e, logic [7:0] g);
    checkWord(name, {24'h000000, e}, {24'h000000, g});
  endtask
  // One APB transfer; whole words only, read data and pslverr kept in rd and err
  task automatic apb(logic wr, logic [PADDR_W-1:0] a, logic [31:0] d);
    int n;
    @(posedge clk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge clk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    if (pready !== 1'b1) begin
      n_fail++;
      test_done();
    end
  endtask
  task automatic sReset();
    repeat (4) @(posedge clk);
    checkPin("oe", DIR_RST, pinOe);
    apb(1'b0, ADDR_LATCH, 32'h00000000);
    checkWord("latch", {24'h000000, LATCH_RST}, rd);
    apb(1'b0, ADDR_READBACK, 32'h00000000);
    checkWord("readback", 32'h0000005A, rd);
  endtask
  task automatic sPins();
    apb(1'b1, ADDR_LATCH, 32'h000000A5);
    apb(1'b1, ADDR_DIR, 32'h0000000F);
    repeat (3) @(posedge clk);
    checkPin("oe", 8'h0F, pinOe);
    checkPin("out", 8'h05, pinOut & pinOe);
    apb(1'b0, ADDR_READBACK, 32'h00000000);
    checkWord("readback", 32'h00000055, rd);
    apb(1'b1, ADDR_READBACK, 32'h000000FF);
    apb(1'b0, ADDR_LATCH, 32'h00000000);
    checkPin("latch", 8'hA5, rd[7:0]);
    apb(1'b0, ADDR_DIR, 32'h00000000);
    checkPin("dir read", DIR_READ_VAL, rd[7:0]);
    apb(1'b0, 18'h00010, 32'h00000000);
    checkPin("slverr", 8'h01, {7'h00, err});
  endtask
  task automatic sTimer();
    apb(1'b1, ADDR_DIR, 32'h00000080);
    extLevel <= 8'h3C;
    cmpLevel <= 2'b01;
    apb(1'b1, ADDR_TSEL, 32'h0003F521);
    repeat (4) @(posedge clk);
    checkPin("tmo oe", 8'hC0, pinOe);
    checkPin("tmo out", 8'h40, pinOut & 8'hC0);
    checkPin("timer in", 8'h0F, {4'h0, t1Clk, t1Clr, t0Clk, t0Clr});
    apb(1'b0, ADDR_READBACK, 32'h00000000);
    checkPin("readback", 8'hFC, rd[7:0]);
    cmpLevel <= 2'b10;
    repeat (3) @(posedge clk);
    checkPin("tmo out", 8'h80, pinOut & 8'hC0);
    apb(1'b1, ADDR_TSEL, 32'h0003BC00);
    repeat (4) @(posedge clk);
    checkPin("tmo off", 8'h80, pinOe);
    checkPin("timer in", 8'h0C, {4'h0, t1Clk, t1Clr, t0Clk, t0Clr});
  endtask
  task automatic sManRst();
    apb(1'b1, ADDR_TSEL, 32'h0003F521);
    apb(1'b1, ADDR_DIR, 32'h000000C3);
    manRst_n <= 1'b0;
    repeat (5) @(posedge clk);
    manRst_n <= 1'b1;
    repeat (4) @(posedge clk);
    checkPin("oe", 8'hC3, pinOe);
    checkPin("out", 8'h81, pinOut & pinOe);
    checkPin("timer in", 8'h00, {4'h0, t1Clk, t1Clr, t0Clk, t0Clr});
    apb(1'b0, ADDR_LATCH, 32'h00000000);
    checkPin("latch", 8'hA5, rd[7:0]);
  endtask
  task automatic sHw();
    hwStandby <= 1'b1;
    repeat (5) @(posedge clk);
    hwStandby <= 1'b0;
    repeat (4) @(posedge clk);
    checkPin("oe", 8'h00, pinOe);
    apb(1'b0, ADDR_LATCH, 32'h00000000);
    checkPin("latch", 8'h00, rd[7:0]);
    apb(1'b0, ADDR_READBACK, 32'h00000000);
    checkPin("readback", 8'h3C, rd[7:0]);
  endtask
  initial begin
    rst_n = 1'b0;
    manRst_n = 1'b1;
    hwStandby = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 18'h00000;
    pwdata = 32'h00000000;
    extLevel = 8'h5A;
    cmpLevel = 2'b00;
    n_fail = 0;
    checked = 0;
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    sReset();
    sPins();
    sTimer();
    sManRst();
    sHw();
    test_done();
  end
endmodule
